/* rtl/tpf_pkg.sv */
// Package for the transmit pause, slot mask and filter register bank.
// Assumes a 32-bit APB slave in the core clock domain at 200 MHz.

package tpf_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] TPF_OFS_FILTER_CMD   = 16'h1038;
  localparam logic [15:0] TPF_OFS_FILTER_RD    = 16'h1038;
  localparam logic [15:0] TPF_OFS_MISC_IFS     = 16'h10f0;
  localparam logic [15:0] TPF_OFS_PAUSE        = 16'h1270;
  localparam logic [15:0] TPF_OFS_SLOT_MASK    = 16'h12f0;
  localparam logic [15:0] TPF_OFS_CLEAR_ALL    = 16'h143c;
  localparam logic [15:0] TPF_OFS_SET_ALL      = 16'h147c;

  // ----------------------------------------------------------------
  // Readback window layout
  // ----------------------------------------------------------------
  localparam logic [15:0] TPF_RD_SPAN          = 16'h07c8;
  localparam logic [15:0] TPF_RD_UNIT_STRIDE   = 16'h0100;
  localparam logic [15:0] TPF_RD_WORD_STRIDE   = 16'h0040;
  localparam logic [15:0] TPF_RD_HIGH_UNIT_OFS = 16'h0004;
  localparam int          TPF_RD_LOW_UNITS     = 8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TPF_PAUSE_REQ_LSB   = 0;
  localparam int TPF_PAUSE_DONE_BIT  = 16;
  localparam int TPF_CMD_MASK_LSB    = 0;
  localparam int TPF_CMD_SLICE_LSB   = 16;
  localparam int TPF_CMD_UNIT_LSB    = 20;
  localparam int TPF_CMD_OP_LSB      = 24;
  localparam int TPF_SLOT_WIN_LSB    = 25;

  // ----------------------------------------------------------------
  // Sizes and values after reset
  // ----------------------------------------------------------------
  localparam int          TPF_UNITS        = 10;
  localparam int          TPF_FILTER_W     = 128;
  localparam int          TPF_SLICE_W      = 16;
  localparam int          TPF_SLOTS        = 16;
  localparam logic [3:0]  TPF_OP_CLEAR     = 4'h0;
  localparam logic [3:0]  TPF_OP_SET       = 4'h1;
  localparam logic [31:0] TPF_PAUSE_RESET  = 32'h00010000;
  localparam logic [15:0] TPF_MASK_RESET   = 16'h0000;
  localparam logic [1:0]  TPF_WIN_RESET    = 2'h0;

endpackage

/* rtl/tpf_bank.sv */
// Transmit pause control, backoff slot mask and per-unit transmit filter.
// Assumes an APB master on i_clk and channel-access units on i_clk too,
// so their status and timing strobes need no synchroniser.
//
// Notes on behaviour
// - Ten pause request bits, one per unit
// - Bit 16 reads 1 once requesters stopped
// - No request pending reads status one
// - Slot mask ignored while window length zero
// - Slot at SIFS expiry is slot 0
// - Slot number advances every slot tick, except when SIFS expires in that cycle
// - Mask bit n blocks slots n mod 16
// - 128 filter bits kept per unit
// - Only mask-enabled slice bits get updated
// - Slice field picks bits 16k+15..16k
// - Unit field 0..9; reserved values ignored
// - Operation 0 clears, 1 sets bits
// - Filter readback at printed offset layout
// - Clear-all command clears unit's filter
// - Set-all command sets unit's filter
// - Window length lives in misc bits 26:25
//
// The APB interface to the registers was decided locally.

`timescale 1ns/1ps
`default_nettype none

module tpf_bank #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // APB slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [ADDR_W-1:0]     i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  output logic [31:0]                o_prdata,
  // Channel-access unit status and slot timing
  input  wire logic [9:0]            i_unit_on_air,
  input  wire logic                  i_sifs_expired,
  input  wire logic                  i_slot_tick,
  // Controls to the channel-access units
  output logic [9:0]                 o_pause_request,
  output logic [9:0]                 o_tx_start_allowed,
  output logic [3:0]                 o_slot_number,
  output logic [10*128-1:0]          o_tx_filter
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic              setup_ph;
  logic              wr_fire;
  logic [15:0]       addr16;
  logic [15:0]       rd_off;
  logic              rd_in_win;
  logic              rd_hit;
  logic [3:0]        rd_unit;
  logic [1:0]        rd_word;

  assign setup_ph = i_psel && !i_penable;
  // Zero wait states: the access phase always completes at once
  assign o_pready = i_psel && i_penable;
  assign wr_fire  = i_psel && i_penable && i_pwrite;
  assign addr16   = 16'(i_paddr);

  // One compare shared by the filter command, clear-all and set-all strobes keeps their decodes alike
  function automatic logic fn_wr_hit(input logic        fire,
                                     input logic [15:0] addr,
                                     input logic [15:0] ofs);
    return fire && (addr == ofs);
  endfunction

  // Readback offsets: units 0..7 at unit*0x100, units 8,9 shifted by 4
  assign rd_off    = addr16 - tpf_pkg::TPF_OFS_FILTER_RD;
  assign rd_in_win = (addr16 >= tpf_pkg::TPF_OFS_FILTER_RD) &&
                     (rd_off < tpf_pkg::TPF_RD_SPAN);
  assign rd_word   = rd_off[7:6];
  always_comb begin
    rd_unit = {1'b0, rd_off[10:8]};
    rd_hit  = 1'b0;
    if (rd_in_win && rd_off[1:0] == 2'b00 && rd_off[5:3] == 3'b000) begin
      if (!rd_off[2]) begin
        rd_hit = 1'b1;
      end else if (rd_off[10:9] == 2'b00) begin
        rd_unit = 4'(tpf_pkg::TPF_RD_LOW_UNITS) + {3'h0, rd_off[8]};
        rd_hit  = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [9:0]        pause_request_bits;
  logic [9:0]        next_pause_request_bits;
  logic [15:0]       slot_mask;
  logic [15:0]       next_slot_mask;
  logic [1:0]        slot_window_length;
  logic [1:0]        next_slot_window_length;

  // Reserved bits are dropped on write and read back as zero
  always_comb begin
    next_pause_request_bits = pause_request_bits;
    next_slot_mask          = slot_mask;
    next_slot_window_length = slot_window_length;
    if (wr_fire) begin
      unique case (addr16)
        tpf_pkg::TPF_OFS_PAUSE: begin
          next_pause_request_bits =
            i_pwdata[tpf_pkg::TPF_PAUSE_REQ_LSB +: 10];
        end
        tpf_pkg::TPF_OFS_SLOT_MASK: begin
          next_slot_mask = i_pwdata[15:0];
        end
        tpf_pkg::TPF_OFS_MISC_IFS: begin
          next_slot_window_length =
            i_pwdata[tpf_pkg::TPF_SLOT_WIN_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pause_request_bits <=
        tpf_pkg::TPF_PAUSE_RESET[tpf_pkg::TPF_PAUSE_REQ_LSB +: 10];
      slot_mask          <= tpf_pkg::TPF_MASK_RESET;
      slot_window_length <= tpf_pkg::TPF_WIN_RESET;
    end else begin
      pause_request_bits <= next_pause_request_bits;
      slot_mask          <= next_slot_mask;
      slot_window_length <= next_slot_window_length;
    end
  end

  assign o_pause_request = pause_request_bits;

  // ----------------------------------------------------------------
  // Pause status
  // ----------------------------------------------------------------
  logic              pause_complete_status;

  // Reads one with no requests, since the AND term is then empty.
  // Judged live when read data is captured: a registered copy would
  // still read one just after a request lands on a transmitting unit.
  always_comb begin
    pause_complete_status =
      ~|(pause_request_bits & i_unit_on_air);
  end

  // ----------------------------------------------------------------
  // Backoff slot counter
  // ----------------------------------------------------------------
  logic [3:0]        slot_number;
  logic [3:0]        next_slot_number;
  logic              slot_ok;

  // Counts modulo 16 by wrapping; SIFS expiry wins over a slot tick
  always_comb begin
    next_slot_number = slot_number;
    if (i_sifs_expired) begin
      next_slot_number = 4'h0;
    end else if (i_slot_tick) begin
      next_slot_number = slot_number + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      slot_number <= 4'h0;
    end else begin
      slot_number <= next_slot_number;
    end
  end

  assign o_slot_number = slot_number;
  assign slot_ok = (slot_window_length == 2'h0) ||
                   !slot_mask[slot_number];
  // A paused unit may end its current frame but may not start another
  assign o_tx_start_allowed = {10{slot_ok}} & ~pause_request_bits;

  // ----------------------------------------------------------------
  // Transmit filters
  // ----------------------------------------------------------------
  logic [127:0]      filter_bits [10];
  logic [127:0]      next_filter_bits [10];
  logic [15:0]       filter_update_mask;
  logic [3:0]        filter_slice_select;
  logic [3:0]        filter_unit_select;
  logic [3:0]        filter_operation;
  logic [127:0]      slice_enable;
  logic [9:0]        filter_clear_all_bits;
  logic [9:0]        filter_set_all_bits;
  logic              cmd_hit;
  logic              clr_hit;
  logic              set_hit;

  assign filter_update_mask  =
    i_pwdata[tpf_pkg::TPF_CMD_MASK_LSB +: 16];
  assign filter_slice_select =
    i_pwdata[tpf_pkg::TPF_CMD_SLICE_LSB +: 4];
  assign filter_unit_select  =
    i_pwdata[tpf_pkg::TPF_CMD_UNIT_LSB +: 4];
  assign filter_operation    =
    i_pwdata[tpf_pkg::TPF_CMD_OP_LSB +: 4];
  assign filter_clear_all_bits = i_pwdata[9:0];
  assign filter_set_all_bits   = i_pwdata[9:0];
  assign cmd_hit = fn_wr_hit(wr_fire, addr16, tpf_pkg::TPF_OFS_FILTER_CMD);
  assign clr_hit = fn_wr_hit(wr_fire, addr16, tpf_pkg::TPF_OFS_CLEAR_ALL);
  assign set_hit = fn_wr_hit(wr_fire, addr16, tpf_pkg::TPF_OFS_SET_ALL);

  // Slices 8..15 wrap the shift, so the command decode refuses them
  assign slice_enable = {112'h0, filter_update_mask} <<
                        (7'(filter_slice_select) * 7'd16);

  always_comb begin
    for (int u = 0; u < tpf_pkg::TPF_UNITS; u++) begin
      next_filter_bits[u] = filter_bits[u];
      if (cmd_hit &&
          filter_unit_select == 4'(u) &&
          filter_slice_select[3] == 1'b0) begin
        if (filter_operation == tpf_pkg::TPF_OP_CLEAR) begin
          next_filter_bits[u] = filter_bits[u] & ~slice_enable;
        end else if (filter_operation == tpf_pkg::TPF_OP_SET) begin
          next_filter_bits[u] = filter_bits[u] | slice_enable;
        end
      end
      if (clr_hit &&
          filter_clear_all_bits[u]) begin
        next_filter_bits[u] = '0;
      end
      // Set-all placed last so it wins if both land on one unit
      if (set_hit &&
          filter_set_all_bits[u]) begin
        next_filter_bits[u] = '1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int u = 0; u < tpf_pkg::TPF_UNITS; u++) begin
      if (i_srst) begin
        filter_bits[u] <= '0;
      end else begin
        filter_bits[u] <= next_filter_bits[u];
      end
    end
  end

  always_comb begin
    for (int u = 0; u < tpf_pkg::TPF_UNITS; u++) begin
      o_tx_filter[u*128 +: 128] = filter_bits[u];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0]       rd_data;
  logic [31:0]       next_rd_data;
  logic              rd_err;
  logic              next_rd_err;
  logic [127:0]      rd_filter;

  assign rd_filter = filter_bits[(rd_unit < 4'd10) ? rd_unit : 4'd0];

  // Captured in the setup phase so read data comes from flops
  always_comb begin
    next_rd_data = rd_data;
    next_rd_err  = rd_err;
    if (setup_ph) begin
      next_rd_data = 32'h0;
      next_rd_err  = 1'b0;
      if (addr16 == tpf_pkg::TPF_OFS_PAUSE) begin
        next_rd_data[tpf_pkg::TPF_PAUSE_REQ_LSB +: 10] = pause_request_bits;
        next_rd_data[tpf_pkg::TPF_PAUSE_DONE_BIT] =
          pause_complete_status;
      end else if (addr16 == tpf_pkg::TPF_OFS_SLOT_MASK) begin
        next_rd_data[15:0] = slot_mask;
      end else if (addr16 == tpf_pkg::TPF_OFS_MISC_IFS) begin
        next_rd_data[tpf_pkg::TPF_SLOT_WIN_LSB +: 2] = slot_window_length;
      end else if (addr16 == tpf_pkg::TPF_OFS_CLEAR_ALL ||
                   addr16 == tpf_pkg::TPF_OFS_SET_ALL) begin
        next_rd_data = 32'h0;
      end else if (!i_pwrite && rd_hit) begin
        next_rd_data = rd_filter[rd_word*32 +: 32];
      end else if (i_pwrite && addr16 == tpf_pkg::TPF_OFS_FILTER_CMD) begin
        next_rd_data = 32'h0;
      end else begin
        next_rd_err = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_data <= 32'h0;
      rd_err  <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_err  <= next_rd_err;
    end
  end

  assign o_prdata  = rd_data;
  assign o_pslverr = o_pready && rd_err;

endmodule

`default_nettype wire

/* test/tpf_bank_sva.sv */
// Port checker of the transmit pause, slot mask and filter bank.
// Assumes it is bound into tpf_bank and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tpf_bank_sva #(
  parameter int ADDR_W = 16
) (
  // Clock, reset and APB
  input wire logic              i_clk,
  input wire logic              i_srst,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic [31:0]       o_prdata,
  // Unit side
  input wire logic [9:0]        i_unit_on_air,
  input wire logic              i_sifs_expired,
  input wire logic              i_slot_tick,
  input wire logic [9:0]        o_pause_request,
  input wire logic [9:0]        o_tx_start_allowed,
  input wire logic [3:0]        o_slot_number,
  input wire logic [1279:0]     o_tx_filter
);
  logic wr;
  logic busy;
  logic idle;
  assign wr   = i_psel && i_penable && i_pwrite;
  assign busy = |(o_pause_request & i_unit_on_air);
  assign idle = ~|o_pause_request;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Read data is loaded at setup, so status is one cycle old
  sequence s_rd_pause;
    i_psel && i_penable && !i_pwrite && i_paddr == tpf_pkg::TPF_OFS_PAUSE;
  endsequence
  sequence s_wr_to(a);
    wr && i_paddr == a;
  endsequence
  chk_pause_bits: assert property (
    s_wr_to(tpf_pkg::TPF_OFS_PAUSE) |=>
    o_pause_request == $past(i_pwdata[9:0])) else $error("pause bits");
  chk_pause_done: assert property (
    s_rd_pause |-> o_prdata[16] == !$past(busy, 1)) else $error("status");
  chk_pause_idle: assert property (
    s_rd_pause |-> !$past(idle, 1) || o_prdata[16]) else $error("idle");
  chk_pause_gate: assert property (
    !(|(o_pause_request & o_tx_start_allowed))) else $error("paused start");
  chk_slot_zero: assert property (
    i_sifs_expired |=> o_slot_number == 4'h0) else $error("slot not zero");
  chk_slot_step: assert property (
    !i_sifs_expired && i_slot_tick |=>
    o_slot_number == $past(o_slot_number) + 4'h1) else $error("slot step");
  chk_filter_hold: assert property (
    wr && i_paddr == tpf_pkg::TPF_OFS_FILTER_CMD &&
    (i_pwdata[15:0] == 16'h0 || i_pwdata[23:20] > 4'h9 ||
     i_pwdata[19] || i_pwdata[27:24] > 4'h1)
    |=> $stable(o_tx_filter)) else $error("filter changed");
  chk_clear_all: assert property (
    s_wr_to(tpf_pkg::TPF_OFS_CLEAR_ALL) ##0 i_pwdata[1]
    |=> o_tx_filter[255:128] == 128'h0) else $error("clear all");
  chk_set_all: assert property (
    s_wr_to(tpf_pkg::TPF_OFS_SET_ALL) ##0 i_pwdata[1]
    |=> &o_tx_filter[255:128]) else $error("set all");
endmodule
bind tpf_bank tpf_bank_sva #(.ADDR_W(ADDR_W)) u_sva (
  .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
  .i_unit_on_air(i_unit_on_air), .i_sifs_expired(i_sifs_expired),
  .i_slot_tick(i_slot_tick), .o_pause_request(o_pause_request),
  .o_tx_start_allowed(o_tx_start_allowed),
  .o_slot_number(o_slot_number), .o_tx_filter(o_tx_filter));
`default_nettype wire

/* test/tpf_unit_model.sv */
// Stand-in for the ten channel-access units and the slot timer.
// Assumes the bank's clock; every unit always has a frame queued.
`timescale 1ns/1ps
`default_nettype none
module tpf_unit_model (
  // Clock, reset and bank controls
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic [9:0] i_allowed,
  input  wire logic       i_sifs_req,
  // Status and timing to the bank
  output logic      [9:0] o_on_air,
  output logic            o_sifs,
  output logic            o_tick
);
  logic [4:0] left [10];
  logic [1:0] phase;
  // Permission counts only at frame start; a frame on air always ends
  always_ff @(posedge i_clk) begin
    phase  <= i_srst ? 2'h0 : phase + 2'h1;
    o_tick <= !i_srst && phase == 2'h3;
    o_sifs <= !i_srst && i_sifs_req;
    for (int u = 0; u < 10; u++) begin
      if (i_srst) left[u] <= 5'h0;
      else if (left[u] != 5'h0) left[u] <= left[u] - 5'h1;
      else if (i_allowed[u]) left[u] <= 5'h14;
    end
  end
  always_comb for (int u = 0; u < 10; u++) o_on_air[u] = left[u] != 5'h0;
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench of the transmit pause, slot and filter bank.
// Assumes tpf_unit_model stands in for the channel-access units.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: mismatch %h", $time, g); end end
module tb;
  typedef struct packed {
    logic [15:0] wa;
    logic [31:0] wd;
    logic [15:0] ra;
    logic [31:0] ex;
  } tpf_row_t;
  logic          clk      = 1'b0;
  logic          srst     = 1'b1;
  logic          psel     = 1'b0;
  logic          penable  = 1'b0;
  logic          pwrite   = 1'b0;
  logic [15:0]   paddr    = 16'h0;
  logic [31:0]   pwdata   = 32'h0;
  logic          sifs_req = 1'b0;
  logic          pready, pslverr, sifs, tick, rerr;
  logic [31:0]   prdata, rdata;
  logic [9:0]    on_air, pause_req, allowed;
  logic [3:0]    slot;
  logic [1279:0] filt;
  int            bad_count   = 0;
  int            checks_done = 0;
  int            n;
  tpf_row_t      rows [14] = '{
    '{16'h12f0, 32'h0000a5a5, 16'h12f0, 32'h0000a5a5},
    '{16'h1038, 32'h0100ffff, 16'h1038, 32'h0000ffff},
    '{16'h1038, 32'h000000f0, 16'h1038, 32'h0000ff0f},
    '{16'h1038, 32'h01018001, 16'h1038, 32'h8001ff0f},
    '{16'h1038, 32'h0197a5a5, 16'h11fc, 32'ha5a50000},
    '{16'h1038, 32'h01841234, 16'h10bc, 32'h00001234},
    '{16'h1038, 32'h017200ff, 16'h1778, 32'h000000ff},
    '{16'h1038, 32'h01a0ffff, 16'h1038, 32'h8001ff0f},
    '{16'h1038, 32'h01000000, 16'h1038, 32'h8001ff0f},
    '{16'h1038, 32'h0108ffff, 16'h1038, 32'h8001ff0f},
    '{16'h1038, 32'h0200ffff, 16'h1038, 32'h8001ff0f},
    '{16'h147c, 32'h00000002, 16'h11b8, 32'hffffffff},
    '{16'h143c, 32'h00000002, 16'h11b8, 32'h00000000},
    '{16'h10f0, 32'h06000000, 16'h10f0, 32'h06000000}};
  tpf_bank uut (.i_clk(clk), .i_srst(srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_unit_on_air(on_air), .i_sifs_expired(sifs),
    .i_slot_tick(tick), .o_pause_request(pause_req),
    .o_tx_start_allowed(allowed), .o_slot_number(slot),
    .o_tx_filter(filt));
  tpf_unit_model model (.i_clk(clk), .i_srst(srst), .i_allowed(allowed),
    .i_sifs_req(sifs_req), .o_on_air(on_air), .o_sifs(sifs), .o_tick(tick));
  initial forever #2.5 clk = ~clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic lim();
    if (n >= 40) begin
      bad_count++;
      $display("Error %0t: wait ran out", $time);
      conclude();
    end
  endtask
  // One idle cycle before each setup keeps drives one per time step
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 40 && pready !== 1'b1; k++) @(posedge clk);
    n = k;
    lim();
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    apb(0, 16'h1270, 0); `CHK(rdata, 32'h00010000)
    apb(0, 16'h0ff0, 0); `CHK({rerr, rdata}, 33'h100000000)
    foreach (rows[i]) begin
      apb(1, rows[i].wa, rows[i].wd);
      apb(0, rows[i].ra, 0); `CHK(rdata, rows[i].ex)
    end
    `CHK(filt[1279-:16], 16'ha5a5)
    apb(1, 16'h12f0, 32'h0000fffe);
    sifs_req <= 1'b1;
    @(posedge clk);
    sifs_req <= 1'b0;
    @(posedge clk);
    #1 `CHK({slot, allowed}, 14'h03ff)
    for (n = 0; n < 40 && slot !== 4'h1; n++) @(posedge clk);
    lim();
    #1 `CHK(allowed, 10'h000)
    apb(1, 16'h10f0, 32'h0);
    @(posedge clk);
    #1 `CHK(allowed, 10'h3ff)
    for (n = 0; n < 40 && on_air[0] !== 1'b0; n++) @(posedge clk);
    for (; n < 40 && on_air[0] !== 1'b1; n++) @(posedge clk);
    lim();
    apb(1, 16'h1270, 32'h00000001);
    repeat (2) @(posedge clk);
    apb(0, 16'h1270, 0); `CHK(rdata, 32'h00000001)
    for (n = 0; n < 40 && on_air[0] !== 1'b0; n++) @(posedge clk);
    lim();
    repeat (3) @(posedge clk);
    apb(0, 16'h1270, 0); `CHK(rdata, 32'h00010001)
    `CHK({on_air[0], pause_req}, 11'h001)
    apb(1, 16'h1270, 32'h0);
    repeat (2) @(posedge clk);
    apb(0, 16'h1270, 0); `CHK(rdata, 32'h00010000)
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    apb(0, 16'h1038, 0); `CHK(filt, 1280'h0)
    conclude();
  end
endmodule
`default_nettype wire
